// *** control_port_register_access_test.sv ***
// Self-checking bench: host end drives device end over both ports.
// Assumes the package, interface and both ends compiled before it.
`timescale 1ns/1ps
module control_port_register_access_test;
	import cpra_pkg::*;
	logic        ref_clk_i;
	logic        rst_n_i;
	logic        mode_sel;
	logic        type_sel;
	logic [2:0]  stat;
	logic        irq_ev;
	logic        rx_fs;
	logic [2:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        gci_mode;
	logic        gci_fs;
	logic        fsx_used;
	int          bad_count;
	int          n_tests;

	cpra_if cp_bus ();
	cpra_device i_cpra_device (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.host_mode_select_i(mode_sel), .port_type_select_i(type_sel), .status_i(stat),
		.irq_event_i(irq_ev), .rx_frame_sync_i(rx_fs), .gci_mode_o(gci_mode),
		.gci_frame_sync_o(gci_fs), .tx_frame_sync_used_o(fsx_used), .cp(cp_bus));
	cpra_host i_cpra_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cp(cp_bus));
	cpra_chk #(.HALF_CYC(SER_HALF_CYC)) i_cpra_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.serial_port_clock(cp_bus.serial_port_clock),
		.serial_port_enable_n(cp_bus.serial_port_enable_n),
		.serial_port_tx_out(cp_bus.serial_port_tx_out), .chip_select_n(cp_bus.chip_select_n),
		.read_write(cp_bus.read_write), .host_data_oe_n(cp_bus.host_data_oe_n),
		.dev_data_oe_n(cp_bus.dev_data_oe_n));

	// Free running 100 MHz clock
	initial begin
		ref_clk_i = 1'h0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task hwr(input logic [2:0] a, input logic [15:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'h1;
		@(posedge ref_clk_i);
		wr <= 1'h0;
		@(posedge ref_clk_i);
	endtask

	task hrd(input logic [2:0] a, output logic [15:0] v);
		addr <= a;
		rd   <= 1'h1;
		@(posedge ref_clk_i);
		rd <= 1'h0;
		#1;
		v = rdata;
		@(posedge ref_clk_i);
	endtask

	// One access on the link, polled until the host goes idle
	task acc(input logic par, input logic rdf, input logic [2:0] nib, input logic [3:0] idx,
		input logic [11:0] dat);
		logic [15:0] v;
		hwr(HREG_ADDR, {7'h00, par, rdf, nib, idx});
		hwr(HREG_DATA, {4'h0, dat});
		hrd(HREG_ADDR, v);
		chk(v, {7'h00, par, rdf, nib, idx});
		hwr(HREG_GO, 16'h0000);
		v = 16'h0001;
		for (int i = 0; i < 2000 && v[0] !== 1'h0; i++) hrd(HREG_STATUS, v);
		chk({15'h0000, v[0]}, 16'h0000);
	endtask

	task rchk(input logic par, input logic [2:0] nib, input logic [3:0] idx,
		input logic [15:0] exp);
		logic [15:0] v;
		acc(par, 1'h1, nib, idx, 12'h000);
		hrd(HREG_RDATA, v);
		chk(v, exp);
	endtask

	// Every register kind written then read back, boundary addresses included
	task t_regs(input logic par);
		logic [11:0] k;
		k = par ? 12'h5A5 : 12'hA3C;
		acc(par, 1'h0, 3'h3, 4'h0, {k[3:0], 8'h00});
		acc(par, 1'h0, NIB_LAST, 4'h0, {k[7:4], 8'h00});
		acc(par, 1'h0, EOC_ADDR, 4'h0, k);
		acc(par, 1'h0, BYTE_ADDR, 4'h5, {4'h0, k[7:0]});
		acc(par, 1'h0, BYTE_ADDR, 4'hF, {4'h0, ~k[7:0]});
		rchk(par, 3'h3, 4'h0, {12'h000, k[3:0]});
		rchk(par, NIB_LAST, 4'h0, {12'h000, k[7:4]});
		rchk(par, EOC_ADDR, 4'h0, {4'h0, k});
		rchk(par, BYTE_ADDR, 4'h5, {8'h00, k[7:0]});
		rchk(par, BYTE_ADDR, 4'hF, {8'h00, ~k[7:0]});
		$display("t_regs done, parallel=%0d", par);
	endtask

	// Request raised by an event, seen in status, cleared by reading nibble 0
	task t_irq(input logic par);
		logic [15:0] v;
		stat   <= 3'h5;
		irq_ev <= 1'h1;
		@(posedge ref_clk_i);
		irq_ev <= 1'h0;
		repeat (10) @(posedge ref_clk_i);
		chk({15'h0000, cp_bus.interrupt_request_n}, 16'h0000);
		hrd(HREG_STATUS, v);
		chk({15'h0000, v[1]}, 16'h0001);
		acc(par, 1'h0, STATUS_NIB, 4'h0, 12'hF00);
		rchk(par, STATUS_NIB, 4'h0, 16'h000D);
		repeat (10) @(posedge ref_clk_i);
		chk({15'h0000, cp_bus.interrupt_request_n}, 16'h0001);
		rchk(par, STATUS_NIB, 4'h0, 16'h0005);
		$display("t_irq done, parallel=%0d", par);
	endtask

	// Option bit switches bus timing and frame sync roles, access continues
	task t_gci(input logic par);
		acc(par, 1'h0, BYTE_ADDR, OPT6_IDX, 12'h001 << OPT6_GCI);
		rx_fs <= 1'h1;
		repeat (8) @(posedge ref_clk_i);
		chk({15'h0000, gci_mode}, 16'h0001);
		chk({15'h0000, fsx_used}, 16'h0000);
		chk({15'h0000, gci_fs}, 16'h0001);
		rx_fs <= 1'h0;
		repeat (8) @(posedge ref_clk_i);
		chk({15'h0000, gci_fs}, 16'h0000);
		rchk(par, BYTE_ADDR, OPT6_IDX, 16'h0001 << OPT6_GCI);
		acc(par, 1'h0, BYTE_ADDR, OPT6_IDX, 12'h000);
		rx_fs <= 1'h1;
		repeat (8) @(posedge ref_clk_i);
		chk({15'h0000, gci_mode}, 16'h0000);
		chk({15'h0000, gci_fs}, 16'h0000);
		chk({15'h0000, fsx_used}, 16'h0001);
		rx_fs <= 1'h0;
		$display("t_gci done, parallel=%0d", par);
	endtask

	// Hang guard
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		bad_count++;
		end_sim();
	end

	// Serial straps first, then a mid-run reset into parallel straps
	initial begin
		rst_n_i   = 1'h0;
		mode_sel  = 1'h1;
		type_sel  = 1'h0;
		stat      = 3'h0;
		irq_ev    = 1'h0;
		rx_fs     = 1'h0;
		addr      = 3'h0;
		wdata     = 16'h0000;
		wr        = 1'h0;
		rd        = 1'h0;
		bad_count = 0;
		n_tests   = 0;
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1'h1;
		repeat (6) @(posedge ref_clk_i);
		t_regs(1'h0);
		t_irq(1'h0);
		t_gci(1'h0);
		rst_n_i  <= 1'h0;
		type_sel <= 1'h1;
		repeat (4) @(posedge ref_clk_i);
		rst_n_i <= 1'h1;
		repeat (6) @(posedge ref_clk_i);
		rchk(1'h1, 3'h3, 4'h0, {12'h000, NIB_RST});
		rchk(1'h1, EOC_ADDR, 4'h0, {4'h0, EOC_RST});
		rchk(1'h1, BYTE_ADDR, 4'h5, {8'h00, BYTE_RST});
		t_regs(1'h1);
		t_irq(1'h1);
		t_gci(1'h1);
		end_sim();
	end
endmodule

// *** cpra_chk.sv ***
// Concurrent checks on the pins joining the host and transceiver ends.
// Assumes the interface signals as plain inputs and one 100 MHz clock domain.
`timescale 1ns/1ps
module cpra_chk #(
	parameter int HALF_CYC = cpra_pkg::SER_HALF_CYC
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic serial_port_clock,
	input  wire logic serial_port_enable_n,
	input  wire logic serial_port_tx_out,
	input  wire logic chip_select_n,
	input  wire logic read_write,
	input  wire logic host_data_oe_n,
	input  wire logic dev_data_oe_n
);
	logic       clk_q;
	logic [7:0] run_q;
	logic [7:0] run_d;
	logic [4:0] bits_q;
	logic [4:0] bits_d;

	// Length of the current clock level and rising edges seen in this frame
	always_comb begin
		run_d  = (serial_port_clock == clk_q) ? run_q + 8'h01 : 8'h00;
		bits_d = serial_port_enable_n ? 5'h00 : bits_q + 5'(serial_port_clock && !clk_q);
	end

	// Helper registers only
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_q  <= 1'h0;
			run_q  <= 8'h00;
			bits_q <= 5'h00;
		end else begin
			clk_q  <= serial_port_clock;
			run_q  <= run_d;
			bits_q <= bits_d;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Parallel read handshake built from its two steps
	sequence s_rd_start;
		$fell(chip_select_n) && read_write;
	endsequence
	sequence s_dev_on;
		##[1:8] !dev_data_oe_n;
	endsequence

	property p_rd_answer;
		s_rd_start |-> s_dev_on;
	endproperty
	property p_dev_drive;
		$fell(dev_data_oe_n) |-> !chip_select_n && read_write;
	endproperty
	property p_dev_release;
		$rose(chip_select_n) |-> ##[1:8] dev_data_oe_n;
	endproperty
	property p_wr_drive;
		$fell(chip_select_n) && !read_write |-> !host_data_oe_n;
	endproperty
	property p_oe_excl;
		!(!dev_data_oe_n && !host_data_oe_n);
	endproperty
	property p_port_excl;
		!chip_select_n |-> serial_port_enable_n;
	endproperty
	property p_clk_in_frame;
		$rose(serial_port_clock) |-> !serial_port_enable_n;
	endproperty
	property p_clk_high;
		$fell(serial_port_clock) |-> run_q >= 8'(HALF_CYC - 1);
	endproperty
	property p_frame_len;
		$rose(serial_port_enable_n) |-> bits_q == 5'h08 || bits_q == 5'h10;
	endproperty
	property p_tx_idle;
		serial_port_enable_n [*6] |-> !serial_port_tx_out;
	endproperty

	a_rd_answer: assert property (p_rd_answer)
		else $error("device did not drive read data");
	a_dev_drive: assert property (p_dev_drive)
		else $error("device drove bus outside a read");
	a_dev_release: assert property (p_dev_release)
		else $error("device held bus after select");
	a_wr_drive: assert property (p_wr_drive)
		else $error("host write without data");
	a_oe_excl: assert property (p_oe_excl)
		else $error("bus driven by both ends");
	a_port_excl: assert property (p_port_excl)
		else $error("both ports active");
	a_clk_in_frame: assert property (p_clk_in_frame)
		else $error("serial clock outside frame");
	a_clk_high: assert property (p_clk_high)
		else $error("serial clock too fast");
	a_frame_len: assert property (p_frame_len)
		else $error("frame length not 8 or 16");
	a_tx_idle: assert property (p_tx_idle)
		else $error("tx active while disabled");
endmodule

// *** cpra_device.sv ***
// Transceiver end: register set reached over serial or parallel port.
// Assumes the host paces the link; all pins are sampled on ref_clk_i.
//
// How it works
// - Serial port runs up to 4 Mbps
// - Straps pick parallel or serial port
// - Option bit three selects GCI bus timing
// - Four serial wires, exchange only while enabled
// - Active-low request; open drain in parallel
// - Nibble access: rw bit, 3-bit address
// - Write data on rx, read data on tx
// - Message register: two bytes or sixteen bits
// - Byte registers via address seven then data
// - Six nibbles, one message, byte registers
// - Parallel byte port qualified by select, rw
// - Pointer write, then one or two reads or one write
// - Nibble write is one byte write
// - Nibble read returns data on bits 0-3
// - Host masks nibble reads with 0F
// - Message write: high nibble then low byte
// - Message read: high nibble then low byte
// - Byte write: pointer then data byte
// - Byte read: pointer then one read
// - GCI mode: rx sync becomes frame sync
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module cpra_device (
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          host_mode_select_i,
	input  wire logic                          port_type_select_i,
	input  wire logic [cpra_pkg::STATUS_W-1:0] status_i,
	input  wire logic                          irq_event_i,
	input  wire logic                          rx_frame_sync_i,
	output logic                               gci_mode_o,
	output logic                               gci_frame_sync_o,
	output logic                               tx_frame_sync_used_o,
	cpra_if.dev                                cp
);
	import cpra_pkg::*;

	logic [15:0]  s1_q, s2_q;
	logic [2:0]   prev_q;
	logic         mode_s, ptype_s, en_n_s, sclk_s, rx_s, cs_n_s, rw_s, fs_s;
	logic [7:0]   dbus_s;
	logic         ser_on, par_on, sclk_rise, sclk_fall, en_end, cs_fall, cs_rise;

	logic [3:0]   nib_q [1:5];
	logic [3:0]   nib_d [1:5];
	logic [11:0]  eoc_q, eoc_d;
	logic [7:0]   byt_q [0:BYTE_REGS-1];
	logic [7:0]   byt_d [0:BYTE_REGS-1];
	logic         pend_q, pend_d, clr_pend;
	logic [4:0]   cnt_q, cnt_d;
	logic [15:0]  sh_q, sh_d;
	logic [3:0]   hdr_q, hdr_d, fld_q, fld_d;
	logic         tx_q, tx_d;
	cpra_pcp_type pst_q, pst_d;
	logic [7:0]   ptr_q, ptr_d, dout_q, dout_d;
	logic [1:0]   left_q, left_d;
	logic         doe_n_q, doe_n_d, irq_q, irq_d, irq_oe_n_q, irq_oe_n_d;
	logic         gci_q, gci_d, fsc_q, fsc_d, fsx_q, fsx_d;

	// Two-stage synchronisers for straps and every link pin
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= 16'hFFFF;
			s2_q <= 16'hFFFF;
		end else begin
			s1_q <= {host_mode_select_i, port_type_select_i, cp.serial_port_enable_n,
				cp.serial_port_clock, cp.serial_port_rx_in, cp.chip_select_n,
				cp.read_write, cp.data_bus, rx_frame_sync_i};
			s2_q <= s1_q;
		end
	end
	assign {mode_s, ptype_s, en_n_s, sclk_s, rx_s, cs_n_s, rw_s, dbus_s, fs_s} = s2_q;

	// Edge detection on synchronised strobes
	assign ser_on    = mode_s & ~ptype_s;
	assign par_on    = mode_s & ptype_s;
	assign sclk_rise = sclk_s & ~prev_q[1];
	assign sclk_fall = ~sclk_s & prev_q[1];
	assign en_end    = en_n_s & ~prev_q[2];
	assign cs_fall   = ~cs_n_s & prev_q[0];
	assign cs_rise   = cs_n_s & ~prev_q[0];

	// Read fields: {nibble or message high nibble, message low or byte}
	function automatic logic [11:0] rd_fields(input logic [2:0] a, input logic [3:0] f);
		logic [3:0] hi;
		logic [7:0] lo;
		hi = NIB_RST;
		lo = byt_q[f];
		if (a == STATUS_NIB) begin
			hi = {pend_q, status_i};
		end else if (a <= NIB_LAST) begin
			hi = nib_q[a];
		end else if (a == EOC_ADDR) begin
			hi = eoc_q[11:8];
			lo = eoc_q[7:0];
		end
		return {hi, lo};
	endfunction

	// Next state of both ports and the shared register set
	always_comb begin
		logic [3:0]  bit4;
		logic [2:0]  pa;
		logic [11:0] pf;
		logic [15:0] frame;
		nib_d = nib_q;
		eoc_d = eoc_q;
		byt_d = byt_q;
		clr_pend = 1'b0;
		cnt_d = cnt_q;
		sh_d = sh_q;
		hdr_d = hdr_q;
		fld_d = fld_q;
		tx_d = tx_q;
		pst_d = pst_q;
		ptr_d = ptr_q;
		dout_d = dout_q;
		left_d = left_q;
		doe_n_d = doe_n_q;
		bit4 = {sh_q[2:0], rx_s};
		pa = ptr_q[6:4];
		pf = rd_fields(pa, ptr_q[3:0]);
		frame = {hdr_q, rd_fields(hdr_q[2:0], fld_q)};
		// Serial port
		if (!ser_on) begin
			cnt_d = 5'h00;
			tx_d = 1'b0;
		end else if (en_n_s) begin
			tx_d = 1'b0;
			if (en_end) begin
				// Message or byte access keeps its header for a second frame
				cnt_d = (cnt_q == 5'(SER_SHORT) && hdr_q[2:1] == 2'b11) ? cnt_q : 5'h00;
			end
		end else begin
			if (sclk_rise && cnt_q < 5'(SER_LONG)) begin
				sh_d = {sh_q[14:0], rx_s};
				cnt_d = cnt_q + 5'h01;
				if (cnt_q == 5'h03) begin
					hdr_d = bit4;
				end
				if (cnt_q == 5'h07) begin
					fld_d = bit4;
					// Status read clears only after its request bit has left on tx
					if (hdr_q[3] == RW_READ && hdr_q[2:0] == STATUS_NIB) begin
						clr_pend = 1'b1;
					end
					if (hdr_q[3] != RW_READ && hdr_q[2:0] != STATUS_NIB && hdr_q[2:0] <= NIB_LAST) begin
						nib_d[hdr_q[2:0]] = bit4;
					end
				end
				if (cnt_q == 5'h0F && hdr_q[3] != RW_READ) begin
					if (hdr_q[2:0] == EOC_ADDR) begin
						eoc_d = {fld_q, sh_q[6:0], rx_s};
					end else if (hdr_q[2:0] == BYTE_ADDR) begin
						byt_d[fld_q] = {sh_q[6:0], rx_s};
					end
				end
			end
			if (sclk_fall) begin
				// Read data leaves on tx after the header
				tx_d = (hdr_q[3] == RW_READ && cnt_q >= 5'h04 && cnt_q < 5'(SER_LONG))
					? frame[4'hF - cnt_q[3:0]] : 1'b0;
			end
		end
		// Parallel port
		if (!par_on) begin
			pst_d = PCP_IDLE;
			doe_n_d = 1'b1;
		end else begin
			if (cs_rise) begin
				doe_n_d = 1'b1;
			end
			if (cs_fall && !rw_s) begin
				if (pst_q == PCP_WDATA) begin
					pst_d = PCP_IDLE;
					if (pa == EOC_ADDR) begin
						eoc_d = {ptr_q[3:0], dbus_s};
					end else begin
						byt_d[ptr_q[3:0]] = dbus_s;
					end
				end else begin
					ptr_d = dbus_s;
					if (dbus_s[7] == RW_READ) begin
						pst_d = PCP_READS;
						left_d = (dbus_s[6:4] == EOC_ADDR) ? 2'h2 : 2'h1;
					end else if (dbus_s[6:4] <= NIB_LAST) begin
						pst_d = PCP_IDLE;
						if (dbus_s[6:4] != STATUS_NIB) begin
							nib_d[dbus_s[6:4]] = dbus_s[3:0];
						end
					end else begin
						pst_d = PCP_WDATA;
					end
				end
			end else if (cs_fall) begin
				doe_n_d = 1'b0;
				dout_d = 8'h00;
				if (pst_q == PCP_READS) begin
					left_d = left_q - 2'h1;
					if (left_q == 2'h1) begin
						pst_d = PCP_IDLE;
					end
					if (pa <= NIB_LAST || left_q == 2'h2) begin
						dout_d = {4'h0, pf[11:8]};
					end else begin
						dout_d = pf[7:0];
					end
					if (pa == STATUS_NIB) begin
						clr_pend = 1'b1;
					end
				end
			end
		end
		// Request flag: a new event wins over a clearing read
		pend_d = (pend_q & ~clr_pend) | irq_event_i;
		irq_d = par_on ? 1'b0 : ~pend_q;
		irq_oe_n_d = par_on ? ~pend_q : ~ser_on;
		gci_d = mode_s & byt_q[OPT6_IDX][OPT6_GCI];
		fsc_d = gci_q & fs_s;
		fsx_d = ~gci_q;
	end

	// State registers
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_q <= 3'h7;
			for (int i = 1; i <= 5; i++) begin
				nib_q[i] <= NIB_RST;
			end
			for (int i = 0; i < BYTE_REGS; i++) begin
				byt_q[i] <= BYTE_RST;
			end
			eoc_q <= EOC_RST;
			pend_q <= 1'b0;
			cnt_q <= 5'h00;
			sh_q <= 16'h0000;
			hdr_q <= 4'h0;
			fld_q <= 4'h0;
			tx_q <= 1'b0;
			pst_q <= PCP_IDLE;
			ptr_q <= 8'h00;
			dout_q <= 8'h00;
			left_q <= 2'h0;
			doe_n_q <= 1'b1;
			irq_q <= 1'b1;
			irq_oe_n_q <= 1'b1;
			gci_q <= 1'b0;
			fsc_q <= 1'b0;
			fsx_q <= 1'b1;
		end else begin
			prev_q <= {en_n_s, sclk_s, cs_n_s};
			nib_q <= nib_d;
			byt_q <= byt_d;
			eoc_q <= eoc_d;
			pend_q <= pend_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			hdr_q <= hdr_d;
			fld_q <= fld_d;
			tx_q <= tx_d;
			pst_q <= pst_d;
			ptr_q <= ptr_d;
			dout_q <= dout_d;
			left_q <= left_d;
			doe_n_q <= doe_n_d;
			irq_q <= irq_d;
			irq_oe_n_q <= irq_oe_n_d;
			gci_q <= gci_d;
			fsc_q <= fsc_d;
			fsx_q <= fsx_d;
		end
	end

	// Pin and user outputs, all registered
	assign cp.serial_port_tx_out = tx_q;
	assign cp.dev_data           = dout_q;
	assign cp.dev_data_oe_n      = doe_n_q;
	assign cp.irq_drv            = irq_q;
	assign cp.irq_oe_n           = irq_oe_n_q;
	assign gci_mode_o            = gci_q;
	assign gci_frame_sync_o      = fsc_q;
	assign tx_frame_sync_used_o  = fsx_q;
endmodule

// *** cpra_host.sv ***
// Host end: runs one register access per command over either port.
// Assumes the port choice matches the device straps; makes the link clock.
`timescale 1ns/1ps
module cpra_host #(
	parameter int HALF_CYC = cpra_pkg::SER_HALF_CYC
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	cpra_if.host             cp
);
	import cpra_pkg::*;

	logic [9:0]   s1_q, s2_q;
	logic         tx_s, irq_s;
	logic [7:0]   dbus_s;
	cpra_hst_type st_q, st_d;
	logic [4:0]   tmr_q, tmr_d;
	logic         half_done;
	logic         par_q, par_d, rd_q, rd_d;
	logic [2:0]   na_q, na_d;
	logic [3:0]   ba_q, ba_d;
	logic [11:0]  wdat_q, wdat_d, res_q, res_d;
	logic [15:0]  cmd_q, cmd_d, rsh_q, rsh_d, rdata_q, rdata_d;
	logic [4:0]   bits_q, bits_d;
	logic [1:0]   ops_q, ops_d;
	logic         sclk_q, sclk_d, en_n_q, en_n_d, mosi_q, mosi_d;
	logic         cs_n_q, cs_n_d, rw_q, rw_d, hoe_n_q, hoe_n_d;
	logic [7:0]   hdat_q, hdat_d;

	// Two-stage synchronisers for device outputs
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= 10'h3FF;
			s2_q <= 10'h3FF;
		end else begin
			s1_q <= {cp.serial_port_tx_out, cp.interrupt_request_n, cp.data_bus};
			s2_q <= s1_q;
		end
	end
	assign {tx_s, irq_s, dbus_s} = s2_q;
	assign half_done = (tmr_q == 5'(HALF_CYC - 1));

	// Command registers and transfer sequencer
	always_comb begin
		st_d = st_q;
		tmr_d = half_done ? 5'h00 : tmr_q + 5'h01;
		par_d = par_q;
		rd_d = rd_q;
		na_d = na_q;
		ba_d = ba_q;
		wdat_d = wdat_q;
		res_d = res_q;
		cmd_d = cmd_q;
		rsh_d = rsh_q;
		bits_d = bits_q;
		ops_d = ops_q;
		sclk_d = sclk_q;
		en_n_d = en_n_q;
		mosi_d = mosi_q;
		cs_n_d = cs_n_q;
		rw_d = rw_q;
		hoe_n_d = hoe_n_q;
		hdat_d = hdat_q;
		rdata_d = 16'h0000;
		if (rd_i) begin
			if (addr_i == HREG_ADDR) begin
				rdata_d = {7'h00, par_q, rd_q, na_q, ba_q};
			end else if (addr_i == HREG_DATA) begin
				rdata_d = {4'h0, wdat_q};
			end else if (addr_i == HREG_STATUS) begin
				rdata_d = {14'h0000, ~irq_s, st_q != H_IDLE};
			end else if (addr_i == HREG_RDATA) begin
				rdata_d = {4'h0, res_q};
			end
		end
		if (wr_i && st_q == H_IDLE) begin
			if (addr_i == HREG_ADDR) begin
				{par_d, rd_d, na_d, ba_d} = wdata_i[8:0];
			end else if (addr_i == HREG_DATA) begin
				wdat_d = wdata_i[11:0];
			end else if (addr_i == HREG_GO) begin
				// Header byte then data byte; byte access sends its index
				cmd_d = {rd_q, na_q, (na_q == BYTE_ADDR) ? ba_q : wdat_q[11:8], wdat_q[7:0]};
				tmr_d = 5'h00;
				st_d = H_SETUP;
				if (par_q) begin
					hdat_d = cmd_d[15:8];
					rw_d = 1'b0;
					hoe_n_d = 1'b0;
					if (rd_q == RW_READ) begin
						ops_d = (na_q == EOC_ADDR) ? 2'h3 : 2'h2;
					end else begin
						ops_d = (na_q > NIB_LAST) ? 2'h2 : 2'h1;
					end
				end else begin
					en_n_d = 1'b0;
					mosi_d = cmd_d[HDR_RW_BIT];
					bits_d = (na_q > NIB_LAST) ? 5'(SER_LONG) : 5'(SER_SHORT);
				end
			end
		end
		case (st_q)
			H_SETUP: begin
				if (half_done) begin
					st_d = H_ACT;
					cs_n_d = ~par_q;
					sclk_d = ~par_q;
				end
			end
			H_ACT: begin
				if (half_done) begin
					if (par_q) begin
						cs_n_d = 1'b1;
						hoe_n_d = 1'b1;
						ops_d = ops_q - 2'h1;
						if (rw_q) begin
							rsh_d = {rsh_q[7:0], dbus_s};
						end
						st_d = H_GAP;
					end else begin
						sclk_d = 1'b0;
						rsh_d = {rsh_q[14:0], tx_s};
						cmd_d = {cmd_q[14:0], 1'b0};
						mosi_d = cmd_q[14];
						bits_d = bits_q - 5'h01;
						st_d = (bits_q == 5'h01) ? H_GAP : H_SETUP;
						en_n_d = (bits_q == 5'h01);
					end
				end
			end
			H_GAP: begin
				if (half_done) begin
					if (par_q && ops_q != 2'h0) begin
						st_d = H_SETUP;
						rw_d = rd_q;
						hoe_n_d = rd_q;
						hdat_d = cmd_q[7:0];
					end else begin
						st_d = H_IDLE;
						if (rd_q == RW_READ) begin
							if (na_q <= NIB_LAST) begin
								res_d = {4'h0, rsh_q[7:0] & NIB_MASK};
							end else if (na_q == EOC_ADDR) begin
								res_d = rsh_q[11:0];
							end else begin
								res_d = {4'h0, rsh_q[7:0]};
							end
						end
					end
				end
			end
			default: begin
				tmr_d = 5'h00;
			end
		endcase
	end

	// State registers
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= H_IDLE;
			tmr_q <= 5'h00;
			par_q <= 1'b0;
			rd_q <= 1'b0;
			na_q <= 3'h0;
			ba_q <= 4'h0;
			wdat_q <= 12'h000;
			res_q <= 12'h000;
			cmd_q <= 16'h0000;
			rsh_q <= 16'h0000;
			rdata_q <= 16'h0000;
			bits_q <= 5'h00;
			ops_q <= 2'h0;
			sclk_q <= 1'b0;
			en_n_q <= 1'b1;
			mosi_q <= 1'b0;
			cs_n_q <= 1'b1;
			rw_q <= 1'b1;
			hoe_n_q <= 1'b1;
			hdat_q <= 8'h00;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			par_q <= par_d;
			rd_q <= rd_d;
			na_q <= na_d;
			ba_q <= ba_d;
			wdat_q <= wdat_d;
			res_q <= res_d;
			cmd_q <= cmd_d;
			rsh_q <= rsh_d;
			rdata_q <= rdata_d;
			bits_q <= bits_d;
			ops_q <= ops_d;
			sclk_q <= sclk_d;
			en_n_q <= en_n_d;
			mosi_q <= mosi_d;
			cs_n_q <= cs_n_d;
			rw_q <= rw_d;
			hoe_n_q <= hoe_n_d;
			hdat_q <= hdat_d;
		end
	end

	// Pin and user outputs, all registered
	assign cp.serial_port_clock    = sclk_q;
	assign cp.serial_port_enable_n = en_n_q;
	assign cp.serial_port_rx_in    = mosi_q;
	assign cp.chip_select_n        = cs_n_q;
	assign cp.read_write           = rw_q;
	assign cp.host_data            = hdat_q;
	assign cp.host_data_oe_n       = hoe_n_q;
	assign rdata_o                 = rdata_q;
endmodule

// *** cpra_if.sv ***
// Pins between the host controller and the transceiver control port.
// Resolves the shared data bus and open-drain request line from enables.
`timescale 1ns/1ps
interface cpra_if;
	logic       serial_port_clock;
	logic       serial_port_enable_n;
	logic       serial_port_rx_in;
	logic       serial_port_tx_out;
	logic       chip_select_n;
	logic       read_write;
	logic [7:0] host_data;
	logic       host_data_oe_n;
	logic [7:0] dev_data;
	logic       dev_data_oe_n;
	logic [7:0] data_bus;
	logic       irq_drv;
	logic       irq_oe_n;
	logic       interrupt_request_n;

	// Wire levels; undriven lines float high through pull-ups
	assign data_bus = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : 8'hFF);
	assign interrupt_request_n = irq_oe_n ? 1'b1 : irq_drv;

	modport dev (
		input  serial_port_clock, serial_port_enable_n, serial_port_rx_in,
		input  chip_select_n, read_write, data_bus,
		output serial_port_tx_out, dev_data, dev_data_oe_n, irq_drv, irq_oe_n
	);
	modport host (
		output serial_port_clock, serial_port_enable_n, serial_port_rx_in,
		output chip_select_n, read_write, host_data, host_data_oe_n,
		input  serial_port_tx_out, data_bus, interrupt_request_n
	);
endinterface

// *** cpra_pkg.sv ***
// Shared constants and types of the control port register access block.
// Assumes one 100 MHz system clock on both ends; no other dependencies.
package cpra_pkg;

	// Clock and serial link timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SER_MAX_BPS   = 4_000_000;
	localparam int SER_BIT_NS    = 1_000_000_000 / SER_MAX_BPS;
	localparam int SER_BIT_CYC   = (SER_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SER_HALF_CYC  = (SER_BIT_CYC + 1) / 2;

	// Access frame layout: {rw, nibble address, nibble field, low byte}
	localparam int       HDR_RW_BIT  = 15;
	localparam int       SER_SHORT   = 8;
	localparam int       SER_LONG    = 16;
	localparam logic     RW_READ     = 1'b1;
	localparam int       STATUS_W    = 3;

	// Nibble address map
	localparam logic [2:0] STATUS_NIB  = 3'h0;
	localparam logic [2:0] NIB_LAST    = 3'h5;
	localparam logic [2:0] EOC_ADDR    = 3'h6;
	localparam logic [2:0] BYTE_ADDR   = 3'h7;
	localparam int         BYTE_REGS   = 16;
	localparam logic [3:0] OPT6_IDX    = 4'h6;
	localparam int         OPT6_GCI    = 3;
	localparam logic [7:0] NIB_MASK    = 8'h0F;

	// Reset values
	localparam logic [3:0]  NIB_RST  = 4'h0;
	localparam logic [11:0] EOC_RST  = 12'h000;
	localparam logic [7:0]  BYTE_RST = 8'h00;

	// Host command port register offsets
	localparam logic [2:0] HREG_ADDR   = 3'h0;
	localparam logic [2:0] HREG_DATA   = 3'h1;
	localparam logic [2:0] HREG_GO     = 3'h2;
	localparam logic [2:0] HREG_STATUS = 3'h3;
	localparam logic [2:0] HREG_RDATA  = 3'h4;

	typedef enum logic [1:0] {
		PCP_IDLE  = 2'b00,
		PCP_WDATA = 2'b01,
		PCP_READS = 2'b11
	} cpra_pcp_type;

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_SETUP = 2'b01,
		H_ACT   = 2'b11,
		H_GAP   = 2'b10
	} cpra_hst_type;

endpackage
